//--- design/fpos_pkg.sv
// Package: opcodes, security register layout, timing counts and state types.
package fpos_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_ENTER_OTP  = 8'hb1;
    localparam logic [7:0] OP_EXIT_OTP   = 8'hc1;
    localparam logic [7:0] OP_READ_SEC   = 8'h2b;
    localparam logic [7:0] OP_WRITE_SEC  = 8'h2f;

    // ------------------------------------------------------------
    // Security status register layout
    // ------------------------------------------------------------
    localparam int         SEC_FACTORY_BIT = 0;
    localparam int         SEC_ULOCK_BIT   = 1;
    localparam int         SEC_PSUSP_BIT   = 2;
    localparam int         SEC_ESUSP_BIT   = 3;
    localparam int         SEC_PFAIL_BIT   = 5;
    localparam int         SEC_EFAIL_BIT   = 6;
    localparam logic       SEC_FLAG_RST    = 1'b0;
    localparam logic [7:0] SEC_RSVD_VALUE  = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 10;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int WAKE_PULSE_WIDTH_NS  = 20;
    localparam int WAKE_RELEASE_DELAY_NS = 2000;
    localparam int CNT_W               = 12;
    localparam logic [CNT_W-1:0] SLEEP_ENTRY_CYC =
        CNT_W'((SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WAKE_PULSE_CYC =
        CNT_W'((WAKE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WAKE_RELEASE_CYC =
        CNT_W'((WAKE_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_ENTER   = 4'h2,
        ST_SLEEP   = 4'h4,
        ST_RELEASE = 4'h8
    } fpos_mode_t;

    typedef struct packed {
        logic             cs_s1;
        logic             cs_s2;
        logic             cs_q;
        logic             ck_s1;
        logic             ck_s2;
        logic             ck_q;
        logic             si_s1;
        logic             si_s2;
        fpos_mode_t       mode;
        logic [CNT_W-1:0] cnt;
        logic [2:0]       bitcnt;
        logic [1:0]       nbytes;
        logic [7:0]       shin;
        logic [7:0]       opcode;
        logic             rd_on;
        logic [2:0]       rd_cnt;
        logic [7:0]       rd_sh;
        logic             so;
        logic             otp;
        logic             ulock;
        logic             loaded;
        logic             lock_pulse;
        logic             program_suspended_flag;
        logic             erase_suspended_flag;
        logic             pfail;
        logic             efail;
    } fpos_regs_t;

endpackage : fpos_pkg

//--- design/fpos_core.sv
// Command logic for deep sleep, secured OTP mode and the security status register.
//
// Contract
// R1: Sleep opcode alone, executed only on byte boundary.
// R2: Wait entry delay, then enter deep sleep.
// R3: Deep sleep ignores every clocked-in instruction.
// R4: Host waits minimum dwell before wake pulse.
// R5: Wake on long-enough low pulse or reset.
// R6: Release delay after wake before standby.
// R7: Enter-OTP opcode alone switches to OTP mode.
// R8: OTP mode blocks main array; area 8K-bit.
// R9: Read/program commands address OTP in OTP mode.
// R10: Locked OTP data cannot be updated.
// R11: No status/security writes during OTP access.
// R12: Exit-OTP opcode alone returns to array access.
// R13: Security read accepted at any time; code accepts it only as the first byte in standby mode.
// R14: Security read shifts out until select rises.
// R15: Byte MSB first, re-sampled every eight clocks.
// R16: Bit0 read-only factory lock indicator.
// R17: Bit1 user lock, set once, permanent.
// R18: Host sends write enable before lock write.
// R19: Bit2 set on program suspend, cleared resume.
// R20: Bit3 set on erase suspend, cleared resume.
// R21: Bit5 program fail, cleared by next success.
// R22: Bit6 erase fail, cleared by next success.
// R23: Volatile flags reset zero; bits 7,4 reserved.
module fpos_core
    import fpos_pkg::*;
(
    // System
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Serial pins
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       si,
    output logic            so,
    output logic            so_oe,
    // Array engine events
    input  wire logic       prog_suspend,
    input  wire logic       prog_resume,
    input  wire logic       erase_suspend,
    input  wire logic       erase_resume,
    input  wire logic       prog_done,
    input  wire logic       prog_fail,
    input  wire logic       erase_done,
    input  wire logic       erase_fail,
    // Non-volatile bits and write latch
    input  wire logic       factory_lock_nv,
    input  wire logic       user_lock_nv,
    input  wire logic       write_latch,
    // Mode and status outputs
    output logic            deep_sleep,
    output logic            standby,
    output logic            otp_mode,
    output logic            array_access,
    output logic            otp_lo_write_en,
    output logic            otp_hi_write_en,
    output logic            status_write_block,
    output logic            user_lock_program,
    output logic [7:0]      sec_reg
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic       rst_meta;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fpos_regs_t s_reg;
    fpos_regs_t s_next;
    logic       cs_rise;
    logic       cs_fall;
    logic       ck_rise;
    logic       ck_fall;
    logic [7:0] byte_in;

    function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c);
        cnt_step = (c == {CNT_W{1'b1}}) ? c : c + {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction : cnt_step

    assign cs_rise = s_reg.cs_s2 & ~s_reg.cs_q;
    assign cs_fall = ~s_reg.cs_s2 & s_reg.cs_q;
    assign ck_rise = s_reg.ck_s2 & ~s_reg.ck_q;
    assign ck_fall = ~s_reg.ck_s2 & s_reg.ck_q;
    assign byte_in = {s_reg.shin[6:0], s_reg.si_s2};

    // R16 factory bit
    always_comb begin
        sec_reg                  = SEC_RSVD_VALUE;
        sec_reg[SEC_FACTORY_BIT] = factory_lock_nv;
        sec_reg[SEC_ULOCK_BIT]   = s_reg.ulock;
        sec_reg[SEC_PSUSP_BIT]   = s_reg.program_suspended_flag;
        sec_reg[SEC_ESUSP_BIT]   = s_reg.erase_suspended_flag;
        sec_reg[SEC_PFAIL_BIT]   = s_reg.pfail;
        sec_reg[SEC_EFAIL_BIT]   = s_reg.efail;
    end

    always_comb begin
        s_next            = s_reg;
        s_next.lock_pulse = 1'b0;
        s_next.cs_s1      = cs_n;
        s_next.cs_s2      = s_reg.cs_s1;
        s_next.cs_q       = s_reg.cs_s2;
        s_next.ck_s1      = sclk;
        s_next.ck_s2      = s_reg.ck_s1;
        s_next.ck_q       = s_reg.ck_s2;
        s_next.si_s1      = si;
        s_next.si_s2      = s_reg.si_s1;

        // The lock bit lives in non-volatile cells; it is copied once after reset.
        if (!s_reg.loaded) begin
            s_next.loaded = 1'b1;
            s_next.ulock  = user_lock_nv;
        end

        // R19 suspend flag, set wins over clear
        if (prog_suspend) begin
            s_next.program_suspended_flag = 1'b1;
        end else if (prog_resume) begin
            s_next.program_suspended_flag = 1'b0;
        end
        // R20 erase suspend flag
        if (erase_suspend) begin
            s_next.erase_suspended_flag = 1'b1;
        end else if (erase_resume) begin
            s_next.erase_suspended_flag = 1'b0;
        end
        // R21 program fail flag
        if (prog_fail) begin
            s_next.pfail = 1'b1;
        end else if (prog_done) begin
            s_next.pfail = 1'b0;
        end
        // R22 erase fail flag
        if (erase_fail) begin
            s_next.efail = 1'b1;
        end else if (erase_done) begin
            s_next.efail = 1'b0;
        end

        // Framing restarts at every select fall.
        if (cs_fall) begin
            s_next.bitcnt = 3'h0;
            s_next.nbytes = 2'h0;
            s_next.rd_on  = 1'b0;
        end

        if (ck_rise && !s_reg.cs_s2) begin
            s_next.shin   = byte_in;
            s_next.bitcnt = s_reg.bitcnt + 3'h1;
            if (s_reg.bitcnt == 3'h7) begin
                s_next.opcode = byte_in;
                if (s_reg.nbytes != 2'h2) begin
                    s_next.nbytes = s_reg.nbytes + 2'h1;
                end
                // R13 security read accepted as first byte in ST_STANDBY only, regardless of array engine state
                if (s_reg.nbytes == 2'h0 && s_reg.mode == ST_STANDBY
                        && byte_in == OP_READ_SEC) begin
                    s_next.rd_on  = 1'b1;
                    s_next.rd_cnt = 3'h0;
                end
            end
        end

        // R15 byte re-sampled every eight clocks
        if (ck_fall && s_reg.rd_on && !s_reg.cs_s2) begin
            s_next.rd_cnt = s_reg.rd_cnt + 3'h1;
            if (s_reg.rd_cnt == 3'h0) begin
                s_next.so    = sec_reg[7];
                s_next.rd_sh = {sec_reg[6:0], 1'b0};
            end else begin
                s_next.so    = s_reg.rd_sh[7];
                s_next.rd_sh = {s_reg.rd_sh[6:0], 1'b0};
            end
        end

        // R14 output ends with select rise
        if (cs_rise) begin
            s_next.rd_on = 1'b0;
        end

        unique case (s_reg.mode)
            ST_STANDBY: begin
                s_next.cnt = '0;
                // R1 single opcode ending on a byte boundary
                if (cs_rise && s_reg.bitcnt == 3'h0 && s_reg.nbytes == 2'h1) begin
                    if (s_reg.opcode == OP_DEEP_SLEEP) begin
                        s_next.mode = ST_ENTER;
                    end
                    // R7 enter OTP mode
                    if (s_reg.opcode == OP_ENTER_OTP) begin
                        s_next.otp = 1'b1;
                    end
                    // R12 leave OTP mode
                    if (s_reg.opcode == OP_EXIT_OTP) begin
                        s_next.otp = 1'b0;
                    end
                    // R11 lock write refused in OTP mode; R17 R18 lock set once
                    if (s_reg.opcode == OP_WRITE_SEC && !s_reg.otp
                            && write_latch && !s_reg.ulock) begin
                        s_next.ulock      = 1'b1;
                        s_next.lock_pulse = 1'b1;
                    end
                end
            end
            // R2 entry delay
            ST_ENTER: begin
                if (s_reg.cnt == SLEEP_ENTRY_CYC - 1'b1) begin
                    s_next.mode = ST_SLEEP;
                    s_next.cnt  = '0;
                end else begin
                    s_next.cnt = cnt_step(s_reg.cnt);
                end
            end
            // R3 instructions ignored; R5 wake pulse measured
            ST_SLEEP: begin
                if (!s_reg.cs_s2) begin
                    s_next.cnt = cnt_step(s_reg.cnt);
                end
                if (cs_rise) begin
                    s_next.cnt = '0;
                    if (s_reg.cnt >= WAKE_PULSE_CYC) begin
                        s_next.mode = ST_RELEASE;
                    end
                end
            end
            // R6 release delay
            ST_RELEASE: begin
                if (s_reg.cnt == WAKE_RELEASE_CYC - 1'b1) begin
                    s_next.mode = ST_STANDBY;
                    s_next.cnt  = '0;
                end else begin
                    s_next.cnt = cnt_step(s_reg.cnt);
                end
            end
            default: begin
                s_next.mode = ST_STANDBY;
                s_next.cnt  = '0;
            end
        endcase
    end

    // R23 volatile flags reset to zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg        <= '0;
            s_reg.cs_s1  <= 1'b1;
            s_reg.cs_s2  <= 1'b1;
            s_reg.cs_q   <= 1'b1;
            s_reg.mode   <= ST_STANDBY;
            s_reg.program_suspended_flag    <= SEC_FLAG_RST;
            s_reg.erase_suspended_flag    <= SEC_FLAG_RST;
            s_reg.pfail  <= SEC_FLAG_RST;
            s_reg.efail  <= SEC_FLAG_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign so                 = s_reg.so;
    assign so_oe              = s_reg.rd_on & ~s_reg.cs_s2;
    assign deep_sleep         = (s_reg.mode == ST_SLEEP);
    assign standby            = (s_reg.mode == ST_STANDBY);
    assign otp_mode           = s_reg.otp;
    // R8 R9 array blocked, reads and programs go to OTP
    assign array_access       = ~s_reg.otp;
    // R10 locked halves refuse updates
    assign otp_lo_write_en    = s_reg.otp & ~s_reg.ulock;
    assign otp_hi_write_en    = s_reg.otp & ~factory_lock_nv;
    // R11 status register writes blocked in OTP mode
    assign status_write_block = s_reg.otp;
    assign user_lock_program  = s_reg.lock_pulse;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int REL_D = int'(WAKE_RELEASE_CYC);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_entry_delay_met: assert property ($rose(deep_sleep) |-> // R2
        $past(s_reg.mode) == ST_ENTER && $past(s_reg.cnt) == SLEEP_ENTRY_CYC - 1'b1)
        else $error("deep sleep entered without full entry delay");
    a_sleep_ignores_cmds: assert property (deep_sleep |=> // R3
        !s_reg.rd_on && $stable(s_reg.otp) && !s_reg.lock_pulse)
        else $error("instruction acted on in deep sleep");
    a_wake_pulse_width: assert property ($rose(s_reg.mode == ST_RELEASE) |-> // R5
        $past(s_reg.cnt) >= WAKE_PULSE_CYC && $past(cs_rise))
        else $error("wake without long enough select pulse");
    a_release_delay_exact: assert property ($rose(s_reg.mode == ST_RELEASE) |-> // R6
        ##REL_D standby)
        else $error("release delay not honoured");
    a_otp_enter_cause: assert property ($rose(otp_mode) |-> // R7
        $past(s_reg.opcode) == OP_ENTER_OTP && $past(cs_rise))
        else $error("OTP mode entered without its opcode");
    a_otp_exit_cause: assert property ($fell(otp_mode) |-> // R12
        $past(s_reg.opcode) == OP_EXIT_OTP && $past(cs_rise))
        else $error("OTP mode left without its opcode");
    a_otp_lock_refused: assert property (s_reg.otp && cs_rise |=> // R11
        !user_lock_program)
        else $error("lock write accepted in OTP mode");
    a_user_lock_sticky: assert property (s_reg.loaded && s_reg.ulock |=> // R17
        s_reg.ulock && !user_lock_program)
        else $error("user lock changed after being set");
    a_read_byte_msb: assert property (s_reg.rd_on && ck_fall && !s_reg.cs_s2 // R15
        && s_reg.rd_cnt == 3'h0 |=> so == $past(sec_reg[7]) && so_oe)
        else $error("security byte not restarted at its MSB");
    a_suspend_set_wins: assert property (prog_suspend || erase_suspend |=> // R19
        (s_reg.program_suspended_flag || !$past(prog_suspend)) && (s_reg.erase_suspended_flag || !$past(erase_suspend)))
        else $error("suspend flag lost against resume");
    a_fail_set_wins: assert property (prog_fail || erase_fail |=> // R21
        (s_reg.pfail || !$past(prog_fail)) && (s_reg.efail || !$past(erase_fail)))
        else $error("fail flag lost against success");

    c_sleep_entered: cover property ($rose(deep_sleep));
    c_wake_done: cover property ($fell(deep_sleep) ##[1:400] standby);
    c_read_security: cover property (so_oe && ck_fall);
    c_lock_written: cover property (user_lock_program);

endmodule : fpos_core

//--- bench/fpos_host.sv
// Host serial controller model that frames commands and collects read data.
module fpos_host #(
    parameter int SLEEP_MIN_DWELL_CYC = 50
) (
    // System
    input  wire logic clk_sys,
    // Serial pins
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    input  wire logic so
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    task automatic half();
        repeat (4) @(negedge clk_sys);
    endtask : half

    // opcode, then rdbits read clocks; chip select raised after the chosen bit counts.
    task automatic frame(input logic [7:0] op, input int nbits, input int rdbits,
                         output logic [15:0] rd);
        rd   = 16'h0000;
        cs_n = 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            si   = op[7-(i%8)];
            sclk = 1'b0;
            half();
            sclk = 1'b1;
            half();
        end
        for (int i = 0; i < rdbits; i++) begin
            si   = ~si;
            sclk = 1'b0;
            half();
            sclk = 1'b1;
            half();
            rd   = {rd[14:0], so};
        end
        sclk = 1'b0;
        half();
        cs_n = 1'b1;
        // Released data line toggles so a stale bit never looks valid.
        si   = ~si;
        repeat (8) @(negedge clk_sys);
    endtask : frame

    // dwell in deep sleep before any wake pulse.
    task automatic dwell();
        repeat (SLEEP_MIN_DWELL_CYC) @(negedge clk_sys);
    endtask : dwell

    // chip select low for a chosen number of cycles.
    task automatic pulse(input int ncyc);
        cs_n = 1'b0;
        repeat (ncyc) @(negedge clk_sys);
        cs_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask : pulse
endmodule : fpos_host

//--- bench/flash_powerdown_otp_security_test.sv
// Self-checking bench for deep sleep, secured OTP mode and the security register.
module flash_powerdown_otp_security_test import fpos_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, nrst, cs_n, sclk, si, so, so_oe;
    logic        factory_lock_nv, user_lock_nv, write_latch;
    logic        deep_sleep, standby, otp_mode, array_access, user_lock_program;
    logic        otp_lo_write_en, otp_hi_write_en, status_write_block;
    logic        prog_suspend, prog_resume, erase_suspend, erase_resume;
    logic        prog_done, prog_fail, erase_done, erase_fail;
    logic [7:0]  sec_reg, ev_drv, exp0;
    logic [15:0] rd;
    logic        e_psb, e_esb, e_pfail, e_efail, e_ulock;
    int          num_errors, total_checks, n_prog;
    int          nbs[3] = '{7, 9, 16};
    realtime     t0;

    assign {prog_suspend, prog_resume, erase_suspend, erase_resume,
            prog_done, prog_fail, erase_done, erase_fail} = ev_drv;

    fpos_core fpos_core_i (.clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
        .si(si), .so(so), .so_oe(so_oe), .prog_suspend(prog_suspend),
        .prog_resume(prog_resume), .erase_suspend(erase_suspend),
        .erase_resume(erase_resume), .prog_done(prog_done), .prog_fail(prog_fail),
        .erase_done(erase_done), .erase_fail(erase_fail),
        .factory_lock_nv(factory_lock_nv), .user_lock_nv(user_lock_nv),
        .write_latch(write_latch), .deep_sleep(deep_sleep), .standby(standby),
        .otp_mode(otp_mode), .array_access(array_access),
        .otp_lo_write_en(otp_lo_write_en), .otp_hi_write_en(otp_hi_write_en),
        .status_write_block(status_write_block),
        .user_lock_program(user_lock_program), .sec_reg(sec_reg));

    fpos_host fpos_host_i (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Counted at the falling edge so the pulse is settled when it is looked at.
    always @(negedge clk_sys) if (user_lock_program === 1'b1) n_prog++;

    task automatic chk_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_byte

    task automatic chk_range(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : chk_range

    function automatic logic [7:0] exp_sec();
        return {1'b0, e_efail, e_pfail, 1'b0, e_esb, e_psb, e_ulock, factory_lock_nv};
    endfunction : exp_sec

    // Set wins over clear when both arrive in the same cycle.
    task automatic events(input logic [7:0] v);
        ev_drv = v;
        @(negedge clk_sys);
        ev_drv  = 8'h00;
        e_psb   = v[7] | (e_psb & ~v[6]);
        e_esb   = v[5] | (e_esb & ~v[4]);
        e_pfail = v[2] | (e_pfail & ~v[3]);
        e_efail = v[0] | (e_efail & ~v[1]);
        @(negedge clk_sys);
    endtask : events

    task automatic do_reset(input int n);
        nrst = 1'b0;
        repeat (n) @(negedge clk_sys);
        nrst = 1'b1;
        {e_psb, e_esb, e_pfail, e_efail} = 4'h0;
        e_ulock = user_lock_nv;
        repeat (8) @(negedge clk_sys);
    endtask : do_reset

    task automatic wait_set(input logic want_sleep);
        for (int k = 0; k < 1000 && (want_sleep ? deep_sleep : standby) !== 1'b1; k++)
            @(negedge clk_sys);
    endtask : wait_set

    task automatic end_test(input string name);
        $display("test %s done, errors %0d", name, num_errors);
    endtask : end_test

    task automatic complete_run();
        $display("checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // The whole sequence needs under 10k cycles, so this limit only trips on a hang.
    initial begin
        #400us;
        num_errors++;
        complete_run();
    end

    initial begin
        {nrst, write_latch, user_lock_nv, factory_lock_nv} = 4'h0;
        {ev_drv, num_errors, total_checks, n_prog} = '0;
        void'($urandom(32'h7198b237));
        do_reset(16);
        chk_bit("standby", 1'b1, standby);
        chk_bit("deep_sleep", 1'b0, deep_sleep);
        chk_byte("sec_reg", exp_sec(), sec_reg);
        end_test("reset");
        repeat (40) begin
            factory_lock_nv = 1'($urandom);
            events(8'($urandom));
            chk_byte("sec_reg", exp_sec(), sec_reg);
        end
        events(8'ha5);
        exp0 = exp_sec();
        fork
            fpos_host_i.frame(OP_READ_SEC, 8, 16, rd);
            begin
                repeat (100) @(negedge clk_sys);
                chk_bit("so_oe", 1'b1, so_oe);
                factory_lock_nv = ~factory_lock_nv;
            end
        join
        chk_byte("read byte0", exp0, rd[15:8]);
        chk_byte("read byte1", exp_sec(), rd[7:0]);
        chk_bit("so_oe", 1'b0, so_oe);
        events(8'h5a);
        chk_byte("sec_reg", exp_sec(), sec_reg);
        end_test("flags");
        write_latch = 1'b1;
        fpos_host_i.frame(OP_ENTER_OTP, 8, 0, rd);
        chk_bit("otp_mode", 1'b1, otp_mode);
        chk_bit("array_access", 1'b0, array_access);
        chk_bit("status_write_block", 1'b1, status_write_block);
        chk_bit("otp_hi_write_en", ~factory_lock_nv, otp_hi_write_en);
        chk_bit("otp_lo_write_en", 1'b1, otp_lo_write_en);
        fpos_host_i.frame(OP_WRITE_SEC, 8, 0, rd);
        chk_byte("sec_reg", exp_sec(), sec_reg);
        fpos_host_i.frame(OP_EXIT_OTP, 8, 0, rd);
        chk_bit("otp_mode", 1'b0, otp_mode);
        chk_bit("array_access", 1'b1, array_access);
        chk_range("lock pulses", 0, 0, n_prog);
        end_test("otp");
        write_latch = 1'b0;
        fpos_host_i.frame(OP_WRITE_SEC, 8, 0, rd);
        chk_byte("sec_reg", exp_sec(), sec_reg);
        // write enable latch set before the lock write.
        write_latch = 1'b1;
        fpos_host_i.frame(OP_WRITE_SEC, 8, 0, rd);
        e_ulock = 1'b1;
        chk_byte("sec_reg", exp_sec(), sec_reg);
        fpos_host_i.frame(OP_WRITE_SEC, 8, 0, rd);
        chk_range("lock pulses", 1, 1, n_prog);
        fpos_host_i.frame(OP_ENTER_OTP, 8, 0, rd);
        chk_bit("otp_lo_write_en", 1'b0, otp_lo_write_en);
        fpos_host_i.frame(OP_EXIT_OTP, 8, 0, rd);
        end_test("lock");
        foreach (nbs[i]) fpos_host_i.frame(OP_DEEP_SLEEP, nbs[i], 0, rd);
        repeat (400) @(negedge clk_sys);
        chk_bit("standby", 1'b1, standby);
        chk_bit("deep_sleep", 1'b0, deep_sleep);
        end_test("framing");
        fpos_host_i.frame(OP_DEEP_SLEEP, 8, 0, rd);
        t0 = $realtime - 80.0;
        chk_bit("standby", 1'b0, standby);
        fpos_host_i.frame(OP_ENTER_OTP, 8, 0, rd);
        chk_bit("otp_mode", 1'b0, otp_mode);
        wait_set(1'b1);
        chk_range("entry cycles", int'(SLEEP_ENTRY_CYC), int'(SLEEP_ENTRY_CYC) + 10,
                  int'(($realtime - t0) / 10.0));
        fpos_host_i.dwell();
        fpos_host_i.pulse(1);
        chk_bit("deep_sleep", 1'b1, deep_sleep);
        fpos_host_i.pulse(10);
        t0 = $realtime - 40.0;
        chk_bit("standby", 1'b0, standby);
        wait_set(1'b0);
        chk_range("release cycles", int'(WAKE_RELEASE_CYC), int'(WAKE_RELEASE_CYC) + 10,
                  int'(($realtime - t0) / 10.0));
        chk_bit("deep_sleep", 1'b0, deep_sleep);
        fpos_host_i.frame(OP_ENTER_OTP, 8, 0, rd);
        chk_bit("otp_mode", 1'b1, otp_mode);
        fpos_host_i.frame(OP_EXIT_OTP, 8, 0, rd);
        end_test("sleep");
        events(8'ha5);
        fpos_host_i.frame(OP_DEEP_SLEEP, 8, 0, rd);
        wait_set(1'b1);
        chk_bit("deep_sleep", 1'b1, deep_sleep);
        user_lock_nv = 1'b1;
        do_reset(3);
        chk_bit("standby", 1'b1, standby);
        chk_bit("deep_sleep", 1'b0, deep_sleep);
        chk_byte("sec_reg", exp_sec(), sec_reg);
        end_test("hard reset");
        complete_run();
    end
endmodule : flash_powerdown_otp_security_test
